// ### fpm_pkg.sv
// package: constants and types for the flash protection mode block
package fpm_pkg;
    // protection modes, one-hot codes
    typedef enum logic [2:0] {
        FPM_OPEN = 3'h1,
        FPM_PROT = 3'h2,
        FPM_KILL = 3'h4
    } fpm_mode_e;
    // flash geometry
    localparam int FPM_ROWS = 128;
    localparam int FPM_ROW_W = 7;
    localparam int FPM_ADDR_W = 14;
    localparam int FPM_ROW_LSB = 7;
    // clock rates for wait-state choice, in MHz
    localparam int FPM_CLK_1WS_MHZ = 48;
    localparam int FPM_CLK_0WS_MHZ = 24;
    localparam logic [7:0] FPM_CLK_0WS_LIM = 8'(FPM_CLK_0WS_MHZ);
    localparam logic [1:0] FPM_WS_AT_0 = 2'h0;
    localparam logic [1:0] FPM_WS_AT_1 = 2'h1;
    // reset values
    localparam fpm_mode_e FPM_MODE_RST = FPM_OPEN;
    localparam logic [FPM_ROWS-1:0] FPM_ROW_RST = '0;
endpackage : fpm_pkg

// ### fpm_acc_if.sv
// interface: one flash access request and its answer
interface fpm_acc_if;
    logic req;
    logic [fpm_pkg::FPM_ADDR_W-1:0] addr;
    logic [1:0] wait_states;
    logic done;
    modport ctl (output req, output addr, output wait_states, input done);
    modport tim (input req, input addr, input wait_states, output done);
endinterface : fpm_acc_if

// ### fpm_timer.sv
// access timer: completes a flash access after the chosen wait states
module fpm_timer
    import fpm_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // access channel
    fpm_acc_if.tim acc
);
    logic [1:0] cnt_q;
    logic busy_q;
    logic done_q;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_q <= 2'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && acc.req) begin
                if (acc.wait_states == FPM_WS_AT_0) begin
                    done_q <= 1'b1;
                end else begin
                    busy_q <= 1'b1;
                    cnt_q <= acc.wait_states - 2'h1;
                end
            end else if (busy_q) begin
                if (cnt_q == 2'h0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 2'h1;
                end
            end
        end
    end
    assign acc.done = done_q;
endmodule : fpm_timer

// ### fpm_ctrl.sv
// flash protection mode control, row protection and access gating
// How it works
// - reset leaves the chip in open mode with no restrictions
// - open may go to protected; protected refuses debug accesses
// - protected returns to open only after full flash erase
// - open may go to kill; kill blocks all debug access
// - kill mode refuses external flash erase requests
// - kill mode is left only by reset; all change requests rejected
// - per-row write block and read block bits
// - system-call path always gets read, write and erase
// - one wait state at 48 MHz, zero at 24 MHz
module fpm_ctrl
    import fpm_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // mode change request
    input wire logic mode_req_in,
    input wire fpm_pkg::fpm_mode_e mode_sel_in,
    input wire logic erase_done_in,
    // row protection setup
    input wire logic row_set_in,
    input wire logic [fpm_pkg::FPM_ROW_W-1:0] row_idx_in,
    input wire logic row_wblk_in,
    input wire logic row_rblk_in,
    // cpu clock rate in MHz
    input wire logic [7:0] cpu_mhz_in,
    // access request: source and kind
    input wire logic acc_req_in,
    input wire logic acc_dbg_in,
    input wire logic acc_ext_in,
    input wire logic acc_sys_in,
    input wire logic acc_wr_in,
    input wire logic acc_erase_in,
    input wire logic [fpm_pkg::FPM_ADDR_W-1:0] acc_addr_in,
    // status and answers
    output fpm_pkg::fpm_mode_e mode_out,
    output logic mode_reject_out,
    output logic acc_done_out,
    output logic acc_deny_out,
    output logic [1:0] wait_states_out
);
    fpm_mode_e mode_q;
    logic reject_q;
    logic erased_q;
    logic [FPM_ROWS-1:0] wblk_q;
    logic [FPM_ROWS-1:0] rblk_q;
    logic [1:0] ws_q;
    logic deny_q;
    logic done_q;
    logic [FPM_ROW_W-1:0] acc_row;
    logic allow;

    fpm_acc_if acc ();

    // erase since entering protected mode
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            erased_q <= 1'b0;
        end else if (mode_q != FPM_PROT) begin
            erased_q <= 1'b0;
        end else if (erase_done_in) begin
            erased_q <= 1'b1;
        end
    end

    // mode transitions
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mode_q <= FPM_MODE_RST;
            reject_q <= 1'b0;
        end else begin
            reject_q <= 1'b0;
            if (mode_req_in) begin
                case (mode_q)
                    FPM_OPEN: begin
                        if (mode_sel_in == FPM_PROT) begin
                            mode_q <= FPM_PROT;
                        end else if (mode_sel_in == FPM_KILL) begin
                            mode_q <= FPM_KILL;
                        end else begin
                            reject_q <= 1'b1;
                        end
                    end
                    FPM_PROT: begin
                        if (mode_sel_in == FPM_OPEN && erased_q) begin
                            mode_q <= FPM_OPEN;
                        end else begin
                            reject_q <= 1'b1;
                        end
                    end
                    FPM_KILL: begin
                        reject_q <= 1'b1;
                    end
                    default: begin
                        mode_q <= FPM_KILL;
                        reject_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // per-row protection bits
    generate
        for (genvar i = 0; i < FPM_ROWS; i++) begin : g_row
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    wblk_q[i] <= FPM_ROW_RST[i];
                    rblk_q[i] <= FPM_ROW_RST[i];
                end else if (row_set_in && row_idx_in == FPM_ROW_W'(i)) begin
                    wblk_q[i] <= row_wblk_in;
                    rblk_q[i] <= row_rblk_in;
                end
            end
        end
    endgenerate

    // wait states from cpu clock rate
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ws_q <= FPM_WS_AT_1;
        end else if (cpu_mhz_in > FPM_CLK_0WS_LIM) begin
            ws_q <= FPM_WS_AT_1;
        end else begin
            ws_q <= FPM_WS_AT_0;
        end
    end

    // access gating
    assign acc_row = acc_addr_in[FPM_ROW_LSB +: FPM_ROW_W];
    always_comb begin
        allow = 1'b1;
        if (acc_sys_in) begin
            allow = 1'b1;
        end else begin
            if (acc_dbg_in && mode_q != FPM_OPEN) begin
                allow = 1'b0;
            end
            if (acc_ext_in && acc_erase_in && mode_q == FPM_KILL) begin
                allow = 1'b0;
            end
            if (acc_wr_in && wblk_q[acc_row]) begin
                allow = 1'b0;
            end
            if (!acc_wr_in && !acc_erase_in && rblk_q[acc_row]) begin
                allow = 1'b0;
            end
        end
    end

    assign acc.req = acc_req_in && allow;
    assign acc.addr = acc_addr_in;
    assign acc.wait_states = ws_q;

    fpm_timer u_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .acc(acc.tim)
    );

    // answers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            deny_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            deny_q <= acc_req_in && !allow;
            done_q <= acc.done;
        end
    end

    assign mode_out = mode_q;
    assign mode_reject_out = reject_q;
    assign acc_done_out = done_q;
    assign acc_deny_out = deny_q;
    assign wait_states_out = ws_q;

    AST_KILL_STAYS: assert property (@(posedge clock_in) disable iff (rst_in)
        mode_q == FPM_KILL |=> mode_q == FPM_KILL)
        else $error("kill mode left");
    AST_OPEN_RESET: assert property (@(posedge clock_in)
        rst_in |=> mode_q == FPM_OPEN)
        else $error("mode not open after reset");
    AST_PROT_EXIT: assert property (@(posedge clock_in) disable iff (rst_in)
        ($past(mode_q) == FPM_PROT && mode_q == FPM_OPEN) |->
        $past(erased_q))
        else $error("left protected without erase");
    AST_DBG_DENY: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc_req_in && acc_dbg_in && !acc_sys_in && mode_q != FPM_OPEN)
        |=> acc_deny_out)
        else $error("debug access not refused");
    AST_KILL_DBG: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc_req_in && acc_dbg_in && !acc_sys_in && mode_q == FPM_KILL)
        |-> !acc.req)
        else $error("debug access passed in kill");
    AST_EXT_ERASE: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc_req_in && acc_ext_in && acc_erase_in && !acc_sys_in &&
        mode_q == FPM_KILL) |=> acc_deny_out)
        else $error("external erase not refused");
    AST_SYS_PASS: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc_req_in && acc_sys_in) |=> !acc_deny_out)
        else $error("system call access refused");
    AST_WS_ONE: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc.req && ws_q == FPM_WS_AT_1 && !$past(acc.req))
        |-> ##1 !acc.done ##1 acc.done)
        else $error("one wait state not applied");
    AST_WS_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc.req && ws_q == FPM_WS_AT_0 && !$past(acc.req))
        |=> acc.done)
        else $error("zero wait access late");
    AST_BAD_CHANGE: assert property (@(posedge clock_in) disable iff (rst_in)
        (mode_req_in && mode_q == FPM_OPEN && mode_sel_in == FPM_OPEN)
        |=> mode_reject_out && mode_q == FPM_OPEN)
        else $error("illegal change not rejected");
    AST_ROW_WBLK: assert property (@(posedge clock_in) disable iff (rst_in)
        (acc_req_in && acc_wr_in && !acc_sys_in && wblk_q[acc_row])
        |=> acc_deny_out)
        else $error("blocked row write passed");
endmodule : fpm_ctrl

// ### fpm_dbg_host.sv
// partner model: debug host and other flash access requesters
module fpm_dbg_host
    import fpm_pkg::*;
(
    // clock
    input wire logic clock_in,
    // access request: {debug, external, syscall, write, erase}
    output logic req_out,
    output logic [4:0] kind_out,
    output logic [FPM_ADDR_W-1:0] addr_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        req_out = 1'b0;
        kind_out = 5'h00;
        addr_out = '0;
    end

    // one-cycle request, then lines show a changed value
    task automatic send(input logic [4:0] k, input logic [FPM_ADDR_W-1:0] a);
        req_out = 1'b1;
        kind_out = k;
        addr_out = a;
        @(posedge clock_in);
        #1;
        req_out = 1'b0;
        kind_out = ~k;
        addr_out = ~a;
    endtask : send
endmodule : fpm_dbg_host

// ### flash_protection_modes_tb_top.sv
// testbench: mode changes, row protection, access gating, wait states
module flash_protection_modes_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fpm_pkg::*;
    localparam logic [4:0] DBG = 5'h10;
    localparam logic [4:0] EXT = 5'h08;
    localparam logic [4:0] SYS = 5'h04;
    localparam logic [4:0] WR = 5'h02;
    localparam logic [4:0] ER = 5'h01;
    logic clock_in, rst_in, mode_req, erase_done, row_set, row_wblk, row_rblk;
    logic req, done, deny, rej;
    fpm_mode_e mode_sel, mode;
    logic [6:0] row_idx;
    logic [7:0] mhz;
    logic [4:0] kind;
    logic [13:0] addr;
    logic [1:0] ws;
    int errors, checks_done;

    fpm_dbg_host i_host (.clock_in(clock_in), .req_out(req),
        .kind_out(kind), .addr_out(addr));
    fpm_ctrl i_dut (.clock_in(clock_in), .rst_in(rst_in),
        .mode_req_in(mode_req), .mode_sel_in(mode_sel),
        .erase_done_in(erase_done), .row_set_in(row_set),
        .row_idx_in(row_idx), .row_wblk_in(row_wblk), .row_rblk_in(row_rblk),
        .cpu_mhz_in(mhz), .acc_req_in(req), .acc_dbg_in(kind[4]),
        .acc_ext_in(kind[3]), .acc_sys_in(kind[2]), .acc_wr_in(kind[1]),
        .acc_erase_in(kind[0]), .acc_addr_in(addr), .mode_out(mode),
        .mode_reject_out(rej), .acc_done_out(done), .acc_deny_out(deny),
        .wait_states_out(ws));

    always #5 clock_in = ~clock_in;

    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic chg(input fpm_mode_e sel, input logic [7:0] em, er);
        mode_sel = sel;
        mode_req = 1'b1;
        tick();
        mode_req = 1'b0;
        check("mode", 8'(mode), em);
        check("reject", 8'(rej), er);
        tick();
    endtask : chg

    task automatic acc(input logic [4:0] k, input logic [13:0] a,
                       input logic [7:0] ed, en);
        int n;
        n = 1;
        i_host.send(k, a);
        while (n < 8 && done !== 1'b1 && deny !== 1'b1) begin
            tick();
            n++;
        end
        check("deny", 8'(deny), ed);
        check("latency", 8'(n), en);
        tick();
    endtask : acc

    task automatic row(input logic [6:0] idx, input logic w, r);
        row_idx = idx;
        row_wblk = w;
        row_rblk = r;
        row_set = 1'b1;
        tick();
        row_set = 1'b0;
    endtask : row

    task automatic t_reset();
        check("mode", 8'(mode), 8'(FPM_OPEN));
        check("ws", 8'(ws), 8'h01);
    endtask : t_reset

    task automatic t_wait();
        acc(DBG, 14'h0000, 8'h00, 8'h03);
        mhz = 8'h18;
        tick();
        tick();
        check("ws", 8'(ws), 8'h00);
        acc(DBG, 14'h0000, 8'h00, 8'h02);
    endtask : t_wait

    task automatic t_rows();
        row(7'h05, 1'b1, 1'b0);
        acc(DBG | WR, 14'h0280, 8'h01, 8'h01);
        acc(DBG, 14'h0280, 8'h00, 8'h02);
        acc(SYS | WR, 14'h0280, 8'h00, 8'h02);
        row(7'h06, 1'b0, 1'b1);
        acc(DBG, 14'h0300, 8'h01, 8'h01);
        acc(DBG | WR, 14'h0300, 8'h00, 8'h02);
        acc(DBG | WR, 14'h027f, 8'h00, 8'h02);
    endtask : t_rows

    task automatic t_modes();
        chg(FPM_OPEN, 8'(FPM_OPEN), 8'h01);
        chg(FPM_PROT, 8'(FPM_PROT), 8'h00);
        acc(DBG, 14'h0000, 8'h01, 8'h01);
        acc(5'h00, 14'h0000, 8'h00, 8'h02);
        chg(FPM_KILL, 8'(FPM_PROT), 8'h01);
        chg(FPM_OPEN, 8'(FPM_PROT), 8'h01);
        erase_done = 1'b1;
        tick();
        erase_done = 1'b0;
        chg(FPM_OPEN, 8'(FPM_OPEN), 8'h00);
        chg(FPM_KILL, 8'(FPM_KILL), 8'h00);
        acc(DBG, 14'h0000, 8'h01, 8'h01);
        acc(EXT | ER, 14'h0000, 8'h01, 8'h01);
        acc(SYS | EXT | ER, 14'h0000, 8'h00, 8'h02);
        chg(FPM_OPEN, 8'(FPM_KILL), 8'h01);
        chg(FPM_PROT, 8'(FPM_KILL), 8'h01);
        chg(FPM_KILL, 8'(FPM_KILL), 8'h01);
    endtask : t_modes

    task automatic close_out();
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        #5000;
        errors++;
        close_out();
    end

    initial begin
        clock_in = 1'b0;
        rst_in = 1'b1;
        mode_req = 1'b0;
        mode_sel = FPM_OPEN;
        erase_done = 1'b0;
        row_set = 1'b0;
        row_idx = 7'h00;
        row_wblk = 1'b0;
        row_rblk = 1'b0;
        mhz = 8'h30;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        t_reset();
        t_wait();
        t_rows();
        t_modes();
        close_out();
    end
endmodule : flash_protection_modes_tb_top
